// ### logic/lgdma_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "lgdma_regs.vh"

// One channel: base/current address and count, mode word
module lgdma_chan (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        master_clear,
  input  wire        wr_addr,
  input  wire        wr_count,
  input  wire        hi_byte,
  input  wire [7:0]  wdata,
  input  wire        mode_wr,
  input  wire        xfer_done,
  output reg  [15:0] cur_addr,
  output reg  [15:0] cur_count,
  output reg  [5:0]  mode,
  output wire        exhausted
);

  reg  [15:0] base_addr;
  reg  [15:0] base_count;
  wire [1:0]  xfer_mode = mode[5:4];
  wire        auto_init = mode[`LGDMA_MODE_AUTO_BIT-2];
  wire        addr_dec  = mode[`LGDMA_MODE_DEC_BIT-2];
  // Cascade and reserved modes carry no transfers of their own
  wire        xfer_ok   = xfer_done & (xfer_mode != `LGDMA_XFER_CASCADE) &
                          (xfer_mode != `LGDMA_XFER_RESERVED); // see R5 see R8

  // Count rolling from zero to all ones marks the end
  assign exhausted = xfer_ok & (cur_count == `LGDMA_COUNT_TERMINAL); // see R18

  // ********************************************************
  // Mode word
  // ********************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= `LGDMA_MODE_RESET; // see R6 see R7
    end else if (master_clear) begin
      mode <= `LGDMA_MODE_RESET; // see R6 see R7
    end else if (mode_wr) begin
      mode <= wdata[7:2]; // see R9
    end
  end

  // ********************************************************
  // Address and count
  // ********************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_addr  <= 16'h0000;
      base_count <= 16'h0000;
      cur_addr   <= 16'h0000;
      cur_count  <= 16'h0000;
    end else if (wr_addr) begin
      if (hi_byte) begin
        base_addr[15:8] <= wdata; // see R19
        cur_addr[15:8]  <= wdata;
      end else begin
        base_addr[7:0] <= wdata;
        cur_addr[7:0]  <= wdata;
      end
    end else if (wr_count) begin
      if (hi_byte) begin
        base_count[15:8] <= wdata; // see R19
        cur_count[15:8]  <= wdata;
      end else begin
        base_count[7:0] <= wdata;
        cur_count[7:0]  <= wdata;
      end
    end else if (exhausted && auto_init) begin
      cur_addr  <= base_addr; // see R7
      cur_count <= base_count;
    end else if (xfer_ok) begin
      cur_count <= cur_count - 16'h0001; // see R18
      cur_addr  <= addr_dec ? cur_addr - 16'h0001 : cur_addr + 16'h0001; // see R6
    end
  end

endmodule // lgdma_chan

`default_nettype wire

// ### logic/lgdma_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "lgdma_regs.vh"

// What this block does
// R1: Groups enabled at reset; command bit 2 disables; upper disable also stops lower.
// R2: Status 7:4 show pending requests; cascade bit ORs lower group requests.
// R3: Status 3:0 show channels that reached end of count.
// R4: Single-mask write changes only channel in bits 1:0; bit 2 masks.
// R5: Mode bits 7:6 pick demand, single or cascade; 10 reserved.
// R6: Mode bit 5 picks address increment or decrement; increment after reset.
// R7: Mode bit 4 reloads address and count after end; cleared by reset.
// R8: Mode bits 3:2 pick verify, write, read, illegal; ignored in cascade.
// R9: Mode write stores bits 7:2 into channel named by bits 1:0.
// R10: Any write to clear-pointer port resets byte pointer; reset does too.
// R11: After pointer clear, first access hits low byte, next the high byte.
// R12: Master clear acts as reset: clears command, status, pointer, sets masks.
// R13: All-mask register writes four mask bits at once and reads them back.
// R14: End of count sets channel mask unless autoinitialize is on.
// R15: Reset and master clear set all four mask bits.
// R16: Masking the upper cascade channel blocks all lower group requests.
// R17: Any write to the unmask-all port clears all four mask bits.
// R18: Count decrements per transfer; rolling past zero marks end of count.
// R19: Address or count write loads base and current; reads return current.
// R20: Command bit 4 picks fixed or rotating priority; fixed after reset.
module lgdma_ctrl (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [15:0] io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata,
  output reg         io_rdata_valid,
  input  wire [7:0]  channel_request_line,
  input  wire [7:0]  xfer_done,
  output reg  [7:0]  request_active,
  output reg  [7:0]  count_exhausted,
  output reg  [1:0]  group_enabled,
  output reg  [1:0]  rotate_priority,
  output wire [47:0] channel_mode_word
);

  // ********************************************************
  // Decode helpers
  // ********************************************************

  // Hit per group for a pair of port offsets
  // Exact compare on all sixteen address bits: the short
  // aliases of the old bus are deliberately not answered
  function [1:0] hit2;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      hit2 = {a == hi, a == lo};
    end
  endfunction

  // Channel register port: {hit, is_count, channel[2:0]}
  // Returns zero when the address is not a channel port; the lower
  // group flags count in bit 0, the word-spaced upper group in bit 1
  function [4:0] chan_dec;
    input [15:0] a;
    begin
      chan_dec = 5'h00;
      if ((a >> 3) == (`LGDMA_LO_CHAN_BASE >> 3)) begin
        chan_dec = {1'b1, a[0], 1'b0, a[2:1]};
      end else if ((a >> 4) == (`LGDMA_HI_CHAN_BASE >> 4) && !a[0]) begin
        chan_dec = {1'b1, a[1], 1'b1, a[3:2]};
      end
    end
  endfunction

  // ********************************************************
  // Request line synchroniser
  // ********************************************************
  // Request pins are asynchronous; only the second flop is read,
  // so each request costs two edges of latency
  wire [7:0] req_sync;

  lgdma_sync #(
    .WIDTH (8)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (channel_request_line),
    .sync_out (req_sync)
  );

  // ********************************************************
  // Port decode
  // ********************************************************
  // Channel address/count port, shared by reads and writes
  wire [4:0] cp       = chan_dec(io_addr);
  wire       cp_hit   = cp[4];
  wire       cp_cnt   = cp[3];
  wire [2:0] cp_ch    = cp[2:0];
  wire       cp_grp   = cp_ch[2];
  // Any read or write of a channel port moves the byte pointer
  wire       chan_acc = (io_wr | io_rd) & cp_hit;

  // Command and status share one port: writes command, reads report
  wire [1:0] cmd_wr   = {2{io_wr}} &
                        hit2(io_addr, `LGDMA_LO_STATUS, `LGDMA_HI_STATUS);
  wire [1:0] stat_rd  = {2{io_rd}} &
                        hit2(io_addr, `LGDMA_LO_STATUS, `LGDMA_HI_STATUS);
  // Mask ports: one channel, unmask all, or all four at once
  wire [1:0] smask_wr = {2{io_wr}} &
                        hit2(io_addr, `LGDMA_LO_SINGLE_MASK, `LGDMA_HI_SINGLE_MASK);
  // Mode port names its channel in the low bits of the data
  wire [1:0] mode_wr  = {2{io_wr}} &
                        hit2(io_addr, `LGDMA_LO_CHAN_MODE, `LGDMA_HI_CHAN_MODE);
  // Pointer clear and master clear act on any written value
  wire [1:0] cbp_wr   = {2{io_wr}} &
                        hit2(io_addr, `LGDMA_LO_CLR_BPTR, `LGDMA_HI_CLR_BPTR);
  wire [1:0] mclr_wr  = {2{io_wr}} &
                        hit2(io_addr, `LGDMA_LO_MASTER_CLR, `LGDMA_HI_MASTER_CLR);
  wire [1:0] cmsk_wr  = {2{io_wr}} &
                        hit2(io_addr, `LGDMA_LO_CLR_MASK, `LGDMA_HI_CLR_MASK);
  wire [1:0] amask_wr = {2{io_wr}} &
                        hit2(io_addr, `LGDMA_LO_ALL_MASK, `LGDMA_HI_ALL_MASK);
  // All-mask port is the only mask state that reads back
  wire [1:0] amask_rd = {2{io_rd}} &
                        hit2(io_addr, `LGDMA_LO_ALL_MASK, `LGDMA_HI_ALL_MASK);

  // ********************************************************
  // Group state
  // ********************************************************
  // Group-wide state: bit g or nibble g belongs to group g
  reg  [1:0]   grp_disable;
  reg  [7:0]   chan_mask;
  reg  [7:0]   done_stat;
  reg  [1:0]   byte_ptr;
  wire [127:0] cur_addr_f;
  wire [127:0] cur_count_f;
  wire [7:0]   exhausted;

  // ********************************************************
  // Channels
  // ********************************************************
  // Eight identical channels; channel n of group g sits at 4*g+n.
  // Master clear leaves their address and count alone.
  // Each channel counts only its own transfer pulses
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_chan
      lgdma_chan u_chan (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .master_clear (mclr_wr[i/4]), // see R12
        .wr_addr      (io_wr & cp_hit & (cp_ch == i) & ~cp_cnt),
        .wr_count     (io_wr & cp_hit & (cp_ch == i) & cp_cnt),
        .hi_byte      (byte_ptr[i/4]), // see R11
        .wdata        (io_wdata),
        .mode_wr      (mode_wr[i/4] & (io_wdata[1:0] == i % 4)), // see R9
        .xfer_done    (xfer_done[i]),
        .cur_addr     (cur_addr_f[16*i +: 16]),
        .cur_count    (cur_count_f[16*i +: 16]),
        .mode         (channel_mode_word[6*i +: 6]),
        .exhausted    (exhausted[i])
      );
    end
  endgenerate

  // Autoinitialize flag of each channel
  // It decides whether end of count also sets the mask
  wire [7:0] auto_init;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_auto
      assign auto_init[i] = channel_mode_word[6*i + `LGDMA_MODE_AUTO_BIT - 2];
    end
  endgenerate

  // Command, masks, end-of-count status and byte pointer per group
  // Loop indices for the per-group and per-channel updates
  integer g;
  integer k;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      grp_disable     <= 2'h0; // see R1
      rotate_priority <= 2'h0; // see R20
      chan_mask       <= {2{`LGDMA_MASK_RESET}}; // see R15
      done_stat       <= 8'h00;
      byte_ptr        <= 2'h0; // see R10
    end else begin
      // Master clear takes the group's command, masks, status and pointer back to reset
      for (g = 0; g < 2; g = g + 1) begin
        if (mclr_wr[g]) begin
          grp_disable[g]       <= 1'b0; // see R12
          rotate_priority[g]   <= 1'b0;
          chan_mask[4*g +: 4]  <= `LGDMA_MASK_RESET; // see R15
          done_stat[4*g +: 4]  <= 4'h0;
          byte_ptr[g]          <= 1'b0;
        end else begin
          if (cmd_wr[g]) begin
            grp_disable[g]     <= io_wdata[`LGDMA_CMD_DISABLE_BIT]; // see R1
            rotate_priority[g] <= io_wdata[`LGDMA_CMD_ROTATE_BIT]; // see R20
          end
          if (smask_wr[g]) begin
            chan_mask[4*g + io_wdata[1:0]] <= io_wdata[`LGDMA_SMASK_SET_BIT]; // see R4
          end
          if (cmsk_wr[g]) begin
            chan_mask[4*g +: 4] <= 4'h0; // see R17
          end
          if (amask_wr[g]) begin
            chan_mask[4*g +: 4] <= io_wdata[3:0]; // see R13
          end
          // Pointer flips on any channel-port access of the group,
          // read or write, so bytes pair low then high
          if (cbp_wr[g]) begin
            byte_ptr[g] <= 1'b0; // see R10
          end else if (chan_acc && cp_grp == g) begin
            byte_ptr[g] <= ~byte_ptr[g]; // see R11
          end
          // A status read clears the end-of-count bits it has shown
          if (stat_rd[g]) begin
            done_stat[4*g +: 4] <= 4'h0;
          end
          // End of count wins over a clear in the same cycle
          for (k = 0; k < 4; k = k + 1) begin
            if (exhausted[4*g + k]) begin
              done_stat[4*g + k] <= 1'b1; // see R3
              if (!auto_init[4*g + k]) begin
                chan_mask[4*g + k] <= 1'b1; // see R14
              end
            end
          end
        end
      end
    end
  end

  // ********************************************************
  // Request status and gating
  // ********************************************************

  // Status shows raw synced lines; masks only gate what the
  // transfer logic is offered
  // Cascade channel reports the OR of the lower group
  wire [7:0] req_stat = {req_sync[7:5], |req_sync[3:0], req_sync[3:0]}; // see R2

  // Upper disable and cascade mask both stop the lower group
  wire       lo_ok = ~grp_disable[0] & ~grp_disable[1] & ~chan_mask[4]; // see R1 see R16
  wire       hi_ok = ~grp_disable[1]; // see R1
  // Command view of the lower group, apart from the cascade mask
  wire       lo_on = ~grp_disable[0] & ~grp_disable[1]; // see R1

  // Registered outputs toward the transfer logic
  // Flops give the transfer logic clean levels, one edge late
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      request_active  <= 8'h00;
      count_exhausted <= 8'h00;
      group_enabled   <= 2'h3; // see R1
    end else begin
      request_active  <= req_sync & ~chan_mask & {{4{hi_ok}}, {4{lo_ok}}}; // see R16
      count_exhausted <= exhausted; // see R18
      group_enabled   <= {hi_ok, lo_on}; // see R1
    end
  end

  // ********************************************************
  // Read path
  // ********************************************************
  reg [15:0] chan_word;
  reg [7:0]  next_rdata;

  // Select the addressed byte of a current register
  // Decodes never overlap; unmapped and write-only ports read zero
  always @* begin
    chan_word = cp_cnt ? cur_count_f[16*cp_ch +: 16] : cur_addr_f[16*cp_ch +: 16]; // see R19
    next_rdata = 8'h00;
    if (cp_hit) begin
      next_rdata = byte_ptr[cp_grp] ? chan_word[15:8] : chan_word[7:0]; // see R11
    end else if (stat_rd[0]) begin
      next_rdata = {req_stat[3:0], done_stat[3:0]}; // see R2 see R3
    end else if (stat_rd[1]) begin
      next_rdata = {req_stat[7:4], done_stat[7:4]}; // see R2 see R3
    end else if (amask_rd[0]) begin
      next_rdata = {4'h0, chan_mask[3:0]}; // see R13
    end else if (amask_rd[1]) begin
      next_rdata = {4'h0, chan_mask[7:4]}; // see R13
    end
  end

  // Read data stands until the next read
  // Valid follows the read strobe one edge late, for as many cycles as the strobe lasts;
  // data holds so a slow reader can still pick it up
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata       <= 8'h00;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata_valid <= io_rd;
      if (io_rd) begin
        io_rdata <= next_rdata;
      end
    end
  end

endmodule // lgdma_ctrl

`default_nettype wire

// ### logic/lgdma_regs.vh
`ifndef LGDMA_REGS_VH
`define LGDMA_REGS_VH

// ********************************************************
// I/O port offsets, lower group (channels 0-3)
// ********************************************************
`define LGDMA_LO_STATUS       16'h0008
`define LGDMA_LO_SINGLE_MASK  16'h000a
`define LGDMA_LO_CHAN_MODE    16'h000b
`define LGDMA_LO_CLR_BPTR     16'h000c
`define LGDMA_LO_MASTER_CLR   16'h000d
`define LGDMA_LO_CLR_MASK     16'h000e
`define LGDMA_LO_ALL_MASK     16'h000f
`define LGDMA_LO_CHAN_BASE    16'h0000

// ********************************************************
// I/O port offsets, upper group (channels 4-7)
// ********************************************************
`define LGDMA_HI_STATUS       16'h00d0
`define LGDMA_HI_SINGLE_MASK  16'h00d4
`define LGDMA_HI_CHAN_MODE    16'h00d6
`define LGDMA_HI_CLR_BPTR     16'h00d8
`define LGDMA_HI_MASTER_CLR   16'h00da
`define LGDMA_HI_CLR_MASK     16'h00dc
`define LGDMA_HI_ALL_MASK     16'h00de
`define LGDMA_HI_CHAN_BASE    16'h00c0

// ********************************************************
// Field positions
// ********************************************************
`define LGDMA_CMD_DISABLE_BIT 2
`define LGDMA_CMD_ROTATE_BIT  4
`define LGDMA_SMASK_SET_BIT   2
`define LGDMA_MODE_XFER_MSB   7
`define LGDMA_MODE_XFER_LSB   6
`define LGDMA_MODE_DEC_BIT    5
`define LGDMA_MODE_AUTO_BIT   4

// ********************************************************
// Encodings and reset values
// ********************************************************
`define LGDMA_XFER_DEMAND     2'h0
`define LGDMA_XFER_SINGLE     2'h1
`define LGDMA_XFER_RESERVED   2'h2
`define LGDMA_XFER_CASCADE    2'h3
`define LGDMA_MASK_RESET      4'hf
`define LGDMA_MODE_RESET      6'h00
`define LGDMA_COUNT_TERMINAL  16'h0000

`endif

// ### logic/lgdma_sync.v
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pin-level request lines
module lgdma_sync #(
  parameter WIDTH = 8
) (
  input  wire             ref_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // lgdma_sync

`default_nettype wire

// ### testbench/legacy_dma_group_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module legacy_dma_group_control_tb;
  logic        ref_clk;
  logic        rst_n;
  logic [15:0] io_addr;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_rdata_valid;
  logic [7:0]  channel_request_line;
  logic [7:0]  xfer_done;
  logic [7:0]  request_active;
  logic [7:0]  count_exhausted;
  logic [1:0]  group_enabled;
  logic [1:0]  rotate_priority;
  logic [47:0] channel_mode_word;
  logic [7:0]  want;
  logic [7:0]  lag;
  logic [15:0] seed;
  logic        tc_seen;
  logic [7:0]  exp_q[$];
  logic [7:0]  d;
  logic [7:0]  e;
  logic [7:0]  m;
  int          bad_count;
  int          n_compared;
  int          i;

  lgdma_ctrl DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .channel_request_line(channel_request_line), .xfer_done(xfer_done),
    .request_active(request_active), .count_exhausted(count_exhausted),
    .group_enabled(group_enabled), .rotate_priority(rotate_priority),
    .channel_mode_word(channel_mode_word)
  );
  lgdma_periph PER (.want(want), .lag(lag), .channel_request_line(channel_request_line));

  // ********************************
  // Clock, helpers and bus tasks
  // ********************************
  always #2 ref_clk = ~ref_clk;

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction

  task automatic finish_test();
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(negedge ref_clk);
    io_wr = 1'b0;
  endtask

  // A read notes its expected byte; the watcher below compares it
  task automatic rd(input logic [15:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    io_addr = a;
    io_rd = 1'b1;
    exp_q.push_back(v);
    @(negedge ref_clk);
    io_rd = 1'b0;
  endtask

  task automatic pulse1();
    @(negedge ref_clk);
    xfer_done = 8'h02;
    @(negedge ref_clk);
    xfer_done = 8'h00;
  endtask

  task automatic wait_req(input logic v);
    int n;
    n = 0;
    while (request_active[0] !== v && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (request_active[0] !== v) begin
      bad_count++;
      finish_test();
    end
  endtask

  // Read answers are compared against the oldest note
  always @(posedge ref_clk)
    if (io_rdata_valid === 1'b1)
      chk(io_rdata, (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx);

  // End-of-count pulses of channel 1 are caught here
  always @(posedge ref_clk)
    if (count_exhausted[1] === 1'b1)
      tc_seen <= 1'b1;

  // Watchdog for the whole run
  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    finish_test();
  end

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    {ref_clk, rst_n, io_wr, io_rd, tc_seen} = 5'h00;
    {io_addr, io_wdata, xfer_done, want, lag} = 48'h0;
    seed = 16'h930f;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    chk({6'h00, group_enabled}, 8'h03);
    chk(channel_mode_word[7:0], 8'h00);
    rd(16'h000f, 8'h0f);
    rd(16'h00de, 8'h0f);
    wr(16'h0008, 8'h10);
    chk({6'h00, rotate_priority}, 8'h01);
    // Masks: unmask all, then one channel at a time
    wr(16'h000e, rnd());
    rd(16'h000f, 8'h00);
    m = 8'h00;
    for (i = 0; i < 4; i++) begin
      wr(16'h000a, 8'h04 | i[7:0]);
      m = m | (8'h01 << i);
      rd(16'h000f, m);
    end
    wr(16'h000a, 8'h02);
    rd(16'h000f, 8'h0b);
    for (i = 0; i < 4; i++) begin
      d = rnd();
      wr((i < 2) ? 16'h000f : 16'h00de, d);
      rd((i < 2) ? 16'h000f : 16'h00de, {4'h0, d[3:0]});
    end
    // Byte pointer: a stray low byte is undone by a clear
    d = rnd();
    e = rnd();
    wr(16'h000c, 8'h00);
    wr(16'h0000, rnd());
    wr(16'h000c, rnd());
    wr(16'h0000, d);
    wr(16'h0000, e);
    wr(16'h000c, 8'h00);
    rd(16'h0000, d);
    rd(16'h0000, e);
    // End of count: count 1 plain, then count 0 with reload
    for (i = 0; i < 2; i++) begin
      wr(16'h000c, 8'h00);
      wr(16'h0003, 8'h01 - i[7:0]);
      wr(16'h0003, 8'h00);
      wr(16'h000b, (i == 1) ? 8'h51 : 8'h41);
      wr(16'h000e, 8'h00);
      tc_seen = 1'b0;
      if (i == 0) pulse1();
      chk({7'h00, tc_seen}, 8'h00);
      pulse1();
      repeat (3) @(negedge ref_clk);
      chk({7'h00, tc_seen}, 8'h01);
      rd(16'h000f, (i == 1) ? 8'h00 : 8'h02);
      rd(16'h0008, 8'h02);
    end
    // Requests and the cascade channel
    wr(16'h00dc, 8'h00);
    d = rnd();
    lag = d & 8'h0f;
    want = 8'h01;
    wait_req(1'b1);
    rd(16'h0008, 8'h10);
    rd(16'h00d0, 8'h10);
    wr(16'h00d4, 8'h04);
    repeat (4) @(negedge ref_clk);
    chk(request_active, 8'h00);
    wr(16'h00d4, 8'h00);
    wait_req(1'b1);
    wr(16'h00d0, 8'h14);
    repeat (3) @(negedge ref_clk);
    chk({request_active[3:0], 3'h0, group_enabled[1]}, 8'h00);
    chk({7'h00, rotate_priority[1]}, 8'h01);
    wr(16'h00da, rnd());
    @(negedge ref_clk);
    chk({6'h00, group_enabled[1], rotate_priority[1]}, 8'h02);
    rd(16'h00de, 8'h0f);
    repeat (4) @(negedge ref_clk);
    chk(request_active, 8'h00);
    want = 8'h00;
    // Modes: demand, single and cascade over both groups
    for (i = 0; i < 8; i++) begin
      d = rnd();
      d[7:6] = i[0] ? 2'b01 : (i[1] ? 2'b11 : 2'b00);
      d[1:0] = i[1:0];
      wr((i < 4) ? 16'h000b : 16'h00d6, d);
      chk({2'b00, channel_mode_word[6*i +: 6]}, {2'b00, d[7:2]});
    end
    // Cascade channel 2 ignores its pulse, single channel 3 ends its count
    xfer_done = 8'h0c;
    @(negedge ref_clk);
    xfer_done = 8'h00;
    rd(16'h0008, 8'h08);
    wr(16'h000d, rnd());
    chk({7'h00, channel_mode_word[23:0] == 24'h000000}, 8'h01);
    rd(16'h000f, 8'h0f);
    rd(16'h0100, 8'h00);
    // Let outstanding reads come back
    for (i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge ref_clk);
    if (exp_q.size() != 0) bad_count++;
    finish_test();
  end
endmodule // legacy_dma_group_control_tb

`default_nettype wire

// ### testbench/lgdma_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module lgdma_ctrl_mon (
  input wire        ref_clk,
  input wire        rst_n,
  input wire [15:0] io_addr,
  input wire        io_wr,
  input wire        io_rd,
  input wire [7:0]  io_wdata,
  input wire [7:0]  io_rdata,
  input wire        io_rdata_valid,
  input wire [7:0]  xfer_done,
  input wire [7:0]  request_active,
  input wire [7:0]  count_exhausted,
  input wire [1:0]  group_enabled,
  input wire [1:0]  rotate_priority,
  input wire [47:0] channel_mode_word
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ********************************
  // Register bus answers
  // ********************************
  property p_rd_valid; io_rd |=> io_rdata_valid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read answer missing");
  property p_no_valid; !io_rd |=> !io_rdata_valid; endproperty
  a_no_valid: assert property (p_no_valid) else $error("spurious read answer");
  property p_unmapped; io_rd && io_addr == 16'h0100 |=> io_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // ********************************
  // Command, clear and mode effects
  // ********************************
  property p_cmd_en;
    io_wr && io_addr == 16'h0008 |-> ##2
      group_enabled[0] == (!$past(io_wdata[2], 2) && group_enabled[1]);
  endproperty
  a_cmd_en: assert property (p_cmd_en) else $error("lower enable wrong");
  property p_rotate; io_wr && io_addr == 16'h00d0 |=> rotate_priority[1] == $past(io_wdata[4]);
  endproperty
  a_rotate: assert property (p_rotate) else $error("priority bit wrong");
  property p_mclr; io_wr && io_addr == 16'h00da |=> !rotate_priority[1] ##1 group_enabled[1];
  endproperty
  a_mclr: assert property (p_mclr) else $error("master clear left command");
  property p_up_off; io_wr && io_addr == 16'h00d0 && io_wdata[2] |-> ##2 request_active == 8'h00;
  endproperty
  a_up_off: assert property (p_up_off) else $error("request after upper disable");
  property p_tc_cause; count_exhausted != 8'h00 |-> (count_exhausted & ~$past(xfer_done)) == 8'h00;
  endproperty
  a_tc_cause: assert property (p_tc_cause) else $error("end of count without transfer");
  property p_mode_hold;
    !(io_wr && (io_addr == 16'h000b || io_addr == 16'h00d6 || io_addr == 16'h000d
      || io_addr == 16'h00da)) |=> $stable(channel_mode_word);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode word changed");
  property p_mode_store;
    io_wr && io_addr == 16'h000b |=>
      6'(channel_mode_word >> (6 * $past(io_wdata[1:0]))) == $past(io_wdata[7:2]);
  endproperty
  a_mode_store: assert property (p_mode_store) else $error("mode word not stored");

  // Main scenarios reached
  c_tc: cover property (count_exhausted[1]);
  c_mclr: cover property (io_wr && io_addr == 16'h000d);
  c_req: cover property (request_active[0]);
endmodule // lgdma_ctrl_mon

bind lgdma_ctrl lgdma_ctrl_mon u_mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
  .xfer_done(xfer_done), .request_active(request_active), .count_exhausted(count_exhausted),
  .group_enabled(group_enabled), .rotate_priority(rotate_priority),
  .channel_mode_word(channel_mode_word)
);

`default_nettype wire

// ### testbench/lgdma_periph.sv
`timescale 1ns/1ps
`default_nettype none

// Peripheral side: request lines settle after a settable lag, unrelated to the clock
module lgdma_periph (
  input  wire      [7:0] want,
  input  wire      [7:0] lag,
  output var logic [7:0] channel_request_line
);
  // Lines start idle and follow the wanted pattern after the lag
  initial channel_request_line = 8'h00;
  always @(want) channel_request_line <= #(lag) want;
endmodule // lgdma_periph

`default_nettype wire
